// [rtl/readout_regs.svh]
// Purpose: Register offsets, field positions, reset values and timing counts of the readout sequencer.
// Assumes: 16-bit registers addressed by 16-bit offsets from the two-wire serial front end.
// Notes:   Definitions only.
`ifndef READOUT_REGS_SVH
`define READOUT_REGS_SVH

`define OFF_Y_START        16'h3002
`define OFF_X_START        16'h3004
`define OFF_Y_END          16'h3006
`define OFF_X_END          16'h3008
`define OFF_FRAME_LINES    16'h300A
`define OFF_LINE_CLOCKS    16'h300C
`define OFF_RESET_CTRL     16'h301A
`define OFF_READ_MODE      16'h3040
`define OFF_EMBED_CTRL     16'h3064
`define OFF_X_ODD_INC      16'h30A2
`define OFF_Y_ODD_INC      16'h30A6
`define OFF_SLAVE_CTRL     16'h30CE
`define OFF_BLACK_CFG      16'h3180
`define OFF_EXTRA_DELAY    16'h3FE0
`define OFF_ANALOG_COMBINE 16'h3FE2
`define OFF_SEQ_STATUS     16'h3FE4

`define BIT_STREAM         2
`define BIT_TRIGGER_EN     8
`define BIT_ROW_COMBINE    12
`define BIT_COL_DIGITAL    13
`define BIT_STATS_EN       7
`define BIT_EMBED_EN       8
`define BIT_SLAVE_EN       4
`define BIT_ANALOG_EN      0
`define BLACK_MSB          7
`define BLACK_LSB          4

`define RST_Y_START        16'h0000
`define RST_X_START        16'h0000
`define RST_Y_END          16'h031F
`define RST_X_END          16'h04FF
`define RST_FRAME_LINES    16'h0340
`define RST_LINE_CLOCKS    16'h0400
`define RST_ODD_INC        16'h0001
`define RST_EMBED_CTRL     16'h0100
`define RST_BLACK_CFG      16'h0080

`define ODD_INC_SKIP2      16'h0003
`define EXTRA_BLANK_ROWS   16'h0008
`define GUARD_CLOCKS       16'h0010

`endif

// [rtl/readout_pkg.sv]
// Purpose: Types shared by the readout sequencer and its output buffer.
// Assumes: Nothing beyond the register header.
// Notes:   Types only.
package readout_pkg;

  typedef enum logic [2:0] {ROW_BLACK, ROW_EMBED, ROW_BLANK, ROW_STATS, ROW_ACTIVE} row_kind_e;

  typedef enum logic [2:0] {ST_STANDBY, ST_RUN, ST_EXTRA, ST_GUARD, ST_WAIT} seq_state_e;

  typedef struct packed {
    row_kind_e   kind;
    logic [15:0] row_addr;
    logic [15:0] col_addr;
    logic        row_combine;
    logic        col_analog;
    logic        col_digital;
    logic        row_start;
  } read_word_s;

endpackage

// [rtl/pair_buffer.sv]
// Purpose: Two-entry buffer carrying read words from the sequencer to the receiver.
// Assumes: Both sides on CLK_I.
// Notes:   in_ready drops only when both entries are full.
`timescale 1ns/1ps
`default_nettype none
module pair_buffer
  import readout_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Filling side.
  input  wire logic       in_valid_i,
  input  wire read_word_s in_word_i,
  output logic            in_ready_o,
  // Draining side.
  output logic            out_valid_o,
  output read_word_s      out_word_o,
  input  wire logic       out_ready_i
);

  read_word_s  mem [2];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  logic        push;
  logic        pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_word_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

// [rtl/readout_timing.sv]
// Purpose: Readout sequencer: window addressing, subsampling, row layout, frame timing, slave sync.
// Assumes: Registers written through the two-wire serial front end's word port.
// Notes:   A receiver stall freezes the sequencer so that no read word is lost.
`timescale 1ns/1ps
`default_nettype none
`include "readout_regs.svh"
module readout_timing
  import readout_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Register word port from the serial front end.
  input  wire logic [15:0] REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [15:0] REG_RDATA_O,
  // Trigger pin.
  input  wire logic        FRAME_SYNC_PULSE_I,
  // Read word stream.
  output logic             READ_VALID_O,
  output read_word_s       READ_WORD_O,
  input  wire logic        READ_READY_I,
  // Sequencer status.
  output logic             FRAME_ACTIVE_O,
  output logic             ROW_OPS_HALT_O
);

  logic [15:0] y_start, x_start, y_end, x_end, frame_lines, line_clocks;
  logic [15:0] reset_ctrl, read_mode, embed_ctrl, x_odd, y_odd;
  logic [15:0] slave_ctrl, black_cfg, extra_delay, analog_cfg;

  seq_state_e  state, next_state;
  logic        sync_s1, sync_s2, sync_s3, sync_edge;
  logic        frame_start, load_wait, tail, push, go, buf_ready, row_end, frame_end_rows;
  logic [15:0] wait_val, wait_cnt, clk_cnt, row_cnt, row_addr, col_addr;
  logic        row_phase;
  logic [15:0] height, width_pairs, min_lines, active_start;
  logic [15:0] f_line, f_len, f_height, f_wpairs, f_ob, f_x_start, f_x_odd, f_y_odd, f_extra;
  logic        f_stats, f_embed, f_row_comb, f_col_dig, f_col_ana;
  row_kind_e   kind;
  read_word_s  word;

  // Number of columns or rows kept after subsampling; assumes an even result.
  function automatic logic [15:0] subsample(input logic [15:0] first, input logic [15:0] last,
                                            input logic [15:0] odd_inc);
    logic [15:0] span;
    span = last - first + 16'h0001;
    subsample = (odd_inc == `ODD_INC_SKIP2) ? (span >> 1) : span;
  endfunction

  // Register writes.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      y_start     <= `RST_Y_START;
      x_start     <= `RST_X_START;
      y_end       <= `RST_Y_END;
      x_end       <= `RST_X_END;
      frame_lines <= `RST_FRAME_LINES;
      line_clocks <= `RST_LINE_CLOCKS;
      reset_ctrl  <= 16'h0000;
      read_mode   <= 16'h0000;
      embed_ctrl  <= `RST_EMBED_CTRL;
      x_odd       <= `RST_ODD_INC;
      y_odd       <= `RST_ODD_INC;
      slave_ctrl  <= 16'h0000;
      black_cfg   <= `RST_BLACK_CFG;
      extra_delay <= 16'h0000;
      analog_cfg  <= 16'h0000;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        `OFF_Y_START:        y_start     <= REG_WDATA_I;
        `OFF_X_START:        x_start     <= REG_WDATA_I;
        `OFF_Y_END:          y_end       <= REG_WDATA_I;
        `OFF_X_END:          x_end       <= REG_WDATA_I;
        `OFF_FRAME_LINES:    frame_lines <= REG_WDATA_I;
        `OFF_LINE_CLOCKS:    line_clocks <= REG_WDATA_I;
        `OFF_RESET_CTRL:     reset_ctrl  <= REG_WDATA_I;
        `OFF_READ_MODE:      read_mode   <= REG_WDATA_I;
        `OFF_EMBED_CTRL:     embed_ctrl  <= REG_WDATA_I;
        `OFF_X_ODD_INC:      x_odd       <= REG_WDATA_I;
        `OFF_Y_ODD_INC:      y_odd       <= REG_WDATA_I;
        `OFF_SLAVE_CTRL:     slave_ctrl  <= REG_WDATA_I;
        `OFF_BLACK_CFG:      black_cfg   <= REG_WDATA_I;
        `OFF_EXTRA_DELAY:    extra_delay <= REG_WDATA_I;
        `OFF_ANALOG_COMBINE: analog_cfg  <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  // Register reads, answered one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `OFF_Y_START:        REG_RDATA_O <= y_start;
        `OFF_X_START:        REG_RDATA_O <= x_start;
        `OFF_Y_END:          REG_RDATA_O <= y_end;
        `OFF_X_END:          REG_RDATA_O <= x_end;
        `OFF_FRAME_LINES:    REG_RDATA_O <= frame_lines;
        `OFF_LINE_CLOCKS:    REG_RDATA_O <= line_clocks;
        `OFF_RESET_CTRL:     REG_RDATA_O <= reset_ctrl;
        `OFF_READ_MODE:      REG_RDATA_O <= read_mode;
        `OFF_EMBED_CTRL:     REG_RDATA_O <= embed_ctrl;
        `OFF_X_ODD_INC:      REG_RDATA_O <= x_odd;
        `OFF_Y_ODD_INC:      REG_RDATA_O <= y_odd;
        `OFF_SLAVE_CTRL:     REG_RDATA_O <= slave_ctrl;
        `OFF_BLACK_CFG:      REG_RDATA_O <= black_cfg;
        `OFF_EXTRA_DELAY:    REG_RDATA_O <= extra_delay;
        `OFF_ANALOG_COMBINE: REG_RDATA_O <= analog_cfg;
        `OFF_SEQ_STATUS:     REG_RDATA_O <= {13'h0000, 3'(state)};
        default:             REG_RDATA_O <= 16'h0000;
      endcase
    end
  end

  // Trigger pin synchroniser and rising-edge detect.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
    end else begin
      sync_s1 <= FRAME_SYNC_PULSE_I;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
    end
  end
  assign sync_edge = sync_s2 && !sync_s3;

  // Live geometry; minimum blanking is black rows plus eight.
  assign height      = subsample(y_start, y_end, y_odd);
  assign width_pairs = subsample(x_start, x_end, x_odd) >> 1;
  assign min_lines   = height + {12'h000, black_cfg[`BLACK_MSB:`BLACK_LSB]} + `EXTRA_BLANK_ROWS;

  // Frame geometry is frozen at frame start so a frame is never torn by a write.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      f_line     <= `RST_LINE_CLOCKS;
      f_len      <= `RST_FRAME_LINES;
      f_height   <= 16'h0000;
      f_wpairs   <= 16'h0000;
      f_ob       <= 16'h0000;
      f_x_start  <= 16'h0000;
      f_x_odd    <= `RST_ODD_INC;
      f_y_odd    <= `RST_ODD_INC;
      f_extra    <= 16'h0000;
      f_stats    <= 1'b0;
      f_embed    <= 1'b0;
      f_row_comb <= 1'b0;
      f_col_dig  <= 1'b0;
      f_col_ana  <= 1'b0;
    end else if (frame_start) begin
      f_line     <= line_clocks;
      f_len      <= (frame_lines < min_lines) ? min_lines : frame_lines;
      f_height   <= height;
      f_wpairs   <= width_pairs;
      f_ob       <= {12'h000, black_cfg[`BLACK_MSB:`BLACK_LSB]};
      f_x_start  <= x_start;
      f_x_odd    <= x_odd;
      f_y_odd    <= y_odd;
      f_extra    <= extra_delay;
      f_stats    <= embed_ctrl[`BIT_STATS_EN];
      f_embed    <= embed_ctrl[`BIT_EMBED_EN];
      f_row_comb <= read_mode[`BIT_ROW_COMBINE] && (y_odd == `ODD_INC_SKIP2);
      f_col_dig  <= read_mode[`BIT_COL_DIGITAL] && (x_odd == `ODD_INC_SKIP2);
      f_col_ana  <= analog_cfg[`BIT_ANALOG_EN] && (x_odd == `ODD_INC_SKIP2);
    end
  end

  // Row layout: black rows, two embedded or blank rows, blanking, active rows, statistics.
  assign active_start = f_len - f_height - (f_stats ? 16'h0002 : 16'h0000);
  always_comb begin
    if (row_cnt < f_ob) begin
      kind = ROW_BLACK;
    end else if (row_cnt < f_ob + 16'h0002) begin
      kind = f_embed ? ROW_EMBED : ROW_BLANK;
    end else if (f_stats && (row_cnt >= f_len - 16'h0002)) begin
      kind = ROW_STATS;
    end else if (row_cnt >= active_start) begin
      kind = ROW_ACTIVE;
    end else begin
      kind = ROW_BLANK;
    end
  end

  // One word per clock carries a pixel pair; the rest of the row is blanking.
  assign push           = (state == ST_RUN) && (clk_cnt < f_wpairs);
  assign go             = !push || buf_ready;
  assign row_end        = (state == ST_RUN) && go && (clk_cnt == f_line - 16'h0001);
  assign frame_end_rows = row_end && (row_cnt == f_len - 16'h0001);

  assign word.kind        = kind;
  assign word.row_addr    = row_addr;
  assign word.col_addr    = col_addr;
  assign word.row_combine = f_row_comb;
  assign word.col_analog  = f_col_ana;
  assign word.col_digital = f_col_dig;
  assign word.row_start   = (clk_cnt == 16'h0000);

  always_comb begin
    next_state  = state;
    frame_start = 1'b0;
    load_wait   = 1'b0;
    wait_val    = 16'h0000;
    tail        = 1'b0;
    case (state)
      ST_STANDBY: begin
        if (reset_ctrl[`BIT_STREAM]) begin
          if (slave_ctrl[`BIT_SLAVE_EN]) begin
            next_state = ST_WAIT;
          end else begin
            next_state  = ST_RUN;
            frame_start = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (frame_end_rows) begin
          if (f_extra != 16'h0000) begin
            next_state = ST_EXTRA;
            load_wait  = 1'b1;
            wait_val   = f_extra - 16'h0001;
          end else begin
            tail = 1'b1;
          end
        end
      end
      ST_EXTRA: begin
        tail = (wait_cnt == 16'h0000);
      end
      ST_GUARD: begin
        if (wait_cnt == 16'h0000) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!reset_ctrl[`BIT_STREAM]) begin
          next_state = ST_STANDBY;
        end else if (sync_edge && reset_ctrl[`BIT_TRIGGER_EN]) begin
          next_state  = ST_RUN;
          frame_start = 1'b1;
        end
      end
      default: next_state = ST_STANDBY;
    endcase
    if (tail) begin
      if (!reset_ctrl[`BIT_STREAM]) begin
        next_state = ST_STANDBY;
      end else if (slave_ctrl[`BIT_SLAVE_EN]) begin
        next_state = ST_GUARD;
        load_wait  = 1'b1;
        wait_val   = `GUARD_CLOCKS - 16'h0001;
      end else begin
        next_state  = ST_RUN;
        frame_start = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ST_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wait_cnt <= 16'h0000;
    end else if (load_wait) begin
      wait_cnt <= wait_val;
    end else if (wait_cnt != 16'h0000) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end
  end

  // Row and column counters and addresses; frozen outside ST_RUN.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      clk_cnt   <= 16'h0000;
      row_cnt   <= 16'h0000;
      row_addr  <= 16'h0000;
      row_phase <= 1'b0;
      col_addr  <= 16'h0000;
    end else if (frame_start) begin
      clk_cnt   <= 16'h0000;
      row_cnt   <= 16'h0000;
      row_addr  <= y_start;
      row_phase <= 1'b0;
      col_addr  <= x_start;
    end else if ((state == ST_RUN) && go) begin
      if (row_end) begin
        clk_cnt  <= 16'h0000;
        row_cnt  <= row_cnt + 16'h0001;
        col_addr <= f_x_start;
        if (kind == ROW_ACTIVE) begin
          row_phase <= ~row_phase;
          row_addr  <= row_phase ? row_addr + f_y_odd : row_addr + 16'h0001;
        end
      end else begin
        clk_cnt <= clk_cnt + 16'h0001;
        if (push) begin
          col_addr <= col_addr + 16'h0001 + f_x_odd;
        end
      end
    end
  end

  pair_buffer u_buffer (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (push),
    .in_word_i   (word),
    .in_ready_o  (buf_ready),
    .out_valid_o (READ_VALID_O),
    .out_word_o  (READ_WORD_O),
    .out_ready_i (READ_READY_I)
  );

  assign FRAME_ACTIVE_O = (state == ST_RUN);
  assign ROW_OPS_HALT_O = (state == ST_WAIT);

  // Checks.
  logic [31:0] period_cnt;
  always_ff @(posedge CLK_I) begin
    if (RST_I || frame_start) begin
      period_cnt <= 32'h0000_0000;
    end else if (((state == ST_RUN) && go) || (state == ST_EXTRA)) begin
      period_cnt <= period_cnt + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  chk_col_step: assert property (push && go && !row_end && (clk_cnt + 16'h0001 < f_wpairs)
    |=> col_addr == $past(col_addr) + 16'h0001 + $past(f_x_odd))
    else $error("column address step wrong");
  chk_skip_four: assert property (push && go && !row_end && (f_x_odd == `ODD_INC_SKIP2)
    |=> col_addr == $past(col_addr) + 16'h0004)
    else $error("skip mode column step is not four");
  chk_row_pair: assert property (row_end && (kind == ROW_ACTIVE) && !row_phase
    |=> row_addr == $past(row_addr) + 16'h0001 && row_phase)
    else $error("second row of pair not adjacent");
  chk_frame_period: assert property (tail && (state != ST_STANDBY)
    |-> period_cnt + 32'h0000_0001 == 32'(f_len) * 32'(f_line) + 32'(f_extra))
    else $error("frame period mismatch");
  chk_min_lines: assert property ((state == ST_RUN)
    |-> f_len >= f_height + f_ob + `EXTRA_BLANK_ROWS)
    else $error("frame shorter than window plus blanking");
  chk_black_rows: assert property ((state == ST_RUN) && (row_cnt < f_ob)
    |-> kind == ROW_BLACK)
    else $error("black row missing");
  chk_embed_rows: assert property ((state == ST_RUN) && (row_cnt >= f_ob)
    && (row_cnt < f_ob + 16'h0002) |-> kind == (f_embed ? ROW_EMBED : ROW_BLANK))
    else $error("embedded row kind wrong");
  chk_stats_rows: assert property ((state == ST_RUN) && f_stats
    && (row_cnt >= f_len - 16'h0002) |-> kind == ROW_STATS)
    else $error("statistics row missing");
  chk_guard_len: assert property ($rose(state == ST_GUARD)
    |-> ##15 (state == ST_GUARD) ##1 (state != ST_GUARD))
    else $error("inactive guard not sixteen clocks");
  chk_free_run: assert property ((state == ST_EXTRA) && (wait_cnt == 16'h0000)
    && reset_ctrl[`BIT_STREAM] && !slave_ctrl[`BIT_SLAVE_EN] |=> state == ST_RUN && row_cnt == 16'h0000)
    else $error("free running frame did not restart");
  chk_halt_wait: assert property ((state == ST_WAIT) && $past(state == ST_WAIT)
    |-> $stable(row_cnt) && $stable(row_addr) && !push)
    else $error("row operations moved while waiting");
  chk_ignore_early: assert property (sync_edge && (state == ST_GUARD)
    && (wait_cnt != 16'h0000) |=> state == ST_GUARD)
    else $error("early sync edge was taken");
  chk_slave_start: assert property ((state == ST_STANDBY) && reset_ctrl[`BIT_STREAM]
    && slave_ctrl[`BIT_SLAVE_EN] |=> state == ST_WAIT)
    else $error("slave start did not wait");

  cov_sync_taken: cover property ((state == ST_WAIT) ##1 (state == ST_RUN));
  cov_skip_active: cover property (push && (kind == ROW_ACTIVE) && (f_x_odd == `ODD_INC_SKIP2));
  cov_stall: cover property (push && !buf_ready);
  cov_extra: cover property ((state == ST_EXTRA) ##1 (state == ST_RUN));

endmodule
`default_nettype wire

// [tb/sync_source.sv]
// Purpose: Far-side controller model that sends frame sync pulses to the trigger pin.
// Assumes: Runs on the readout clock; one request per call.
// Notes:   Each request makes a pulse exactly three clocks wide, low otherwise.
`timescale 1ns/1ps
`default_nettype none
module sync_source (
  // Clock and request.
  input  wire logic clk_i,
  input  wire logic fire_i,
  // Trigger pin.
  output logic      pulse_o
);
  logic [1:0] left = 2'h0;

  always @(posedge clk_i) begin
    if (fire_i) begin
      left <= 2'h3;
    end else if (left != 2'h0) begin
      left <= left - 2'h1;
    end
  end

  assign pulse_o = (left != 2'h0);
endmodule
`default_nettype wire

// [tb/readout_timing_tb.sv]
// Purpose: Self-checking bench of the readout sequencer.
// Assumes: Register word port driven directly; sync pulses come from the partner model.
// Notes:   An 8x8 window with 2x skip and short rows keeps each frame near 130 clocks.
`timescale 1ns/1ps
`default_nettype none
module readout_timing_tb;
  import readout_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        sync;
  logic        fire = 1'b0;
  logic        rvalid;
  read_word_s  rword;
  read_word_s  snap;
  logic        rready = 1'b1;
  logic        active;
  logic        halt;
  int          bad_count = 0;
  int          compares = 0;
  int          n_black = 0;
  int          n_embed = 0;
  logic [15:0] rows[$];
  logic [15:0] last_col;
  int          n;
  int          n_blank = 0;
  int          n_stats = 0;
  int          cyc = 0;
  int          t0;
  logic [15:0] exp_step = 16'h0004;
  logic [15:0] exp_flags = 16'h0007;
  // Window 0..7 both ways, odd increments 3, bin flags on, 16 rows of 8 clocks, extra 5.
  logic [15:0] cfg_a[12] = '{16'h3002, 16'h3006, 16'h3004, 16'h3008, 16'h300A, 16'h300C,
                             16'h30A2, 16'h30A6, 16'h3040, 16'h3FE2, 16'h3180, 16'h3FE0};
  logic [15:0] cfg_d[12] = '{16'h0000, 16'h0007, 16'h0000, 16'h0007, 16'h0010, 16'h0008,
                             16'h0003, 16'h0003, 16'h3000, 16'h0001, 16'h0020, 16'h0005};

  always #25 clk = ~clk;

  readout_timing DUT (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .FRAME_SYNC_PULSE_I(sync),
    .READ_VALID_O(rvalid), .READ_WORD_O(rword), .READ_READY_I(rready),
    .FRAME_ACTIVE_O(active), .ROW_OPS_HALT_O(halt));
  sync_source partner (.clk_i(clk), .fire_i(fire), .pulse_o(sync));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Words are judged as they leave the buffer.
  always @(posedge clk) begin
    cyc++;
    if (rvalid === 1'b1 && rready && rword.row_start === 1'b1) begin
      if (rword.kind === ROW_BLACK) n_black++;
      if (rword.kind === ROW_EMBED) n_embed++;
      if (rword.kind === ROW_BLANK) n_blank++;
      if (rword.kind === ROW_STATS) n_stats++;
      if (rword.kind === ROW_ACTIVE) rows.push_back(rword.row_addr);
    end
    if (rvalid === 1'b1 && rready && rword.kind === ROW_ACTIVE) begin
      if (rword.row_start === 1'b1) chk(rword.col_addr, 16'h0000);
      else chk(rword.col_addr, last_col + exp_step);
      chk(16'({rword.row_combine, rword.col_analog, rword.col_digital}), exp_flags);
      last_col = rword.col_addr;
    end
  end

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    #1;
    chk(rdata, exp);
  endtask

  task automatic wait_on(input bit use_halt, input logic want, output int cnt);
    cnt = 0;
    while ((use_halt ? halt : active) !== want && cnt < 400) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 400) begin
      bad_count++;
      $display("[FAIL] t=%0t wait limit got=%h exp=%h", $time, use_halt ? halt : active, want);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (cfg_a[i]) wr_reg(cfg_a[i], cfg_d[i]);
  endtask

  task automatic send_sync();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic test_regs();
    rd_reg(16'h3064, 16'h0100);
    rd_reg(16'h1234, 16'h0000);
    rd_reg(16'h3180, 16'h0020);
    $display("test_regs done");
  endtask

  task automatic test_free();
    wr_reg(16'h301A, 16'h0004);
    wait_on(1'b0, 1'b1, n);
    n_black = 0;
    n_embed = 0;
    rows.delete();
    wait_on(1'b0, 1'b0, n);
    chk(16'(n), 16'h0080);
    wait_on(1'b0, 1'b1, n);
    chk(16'(n), 16'h0005);
    chk(16'(n_black), 16'h0002);
    chk(16'(n_embed), 16'h0002);
    chk(16'(rows.size()), 16'h0004);
    chk({rows[0][3:0], rows[1][3:0], rows[2][3:0], rows[3][3:0]}, 16'h0145);
    repeat (3) @(posedge clk);
    rready <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    snap = rword;
    repeat (4) @(posedge clk);
    #1;
    chk({rvalid, 15'(rword === snap)}, 16'h8001);
    @(posedge clk);
    rready <= 1'b1;
    $display("test_free done");
  endtask

  task automatic test_slave();
    do_reset();
    wr_reg(16'h30CE, 16'h0010);
    wr_reg(16'h301A, 16'h0100);
    wr_reg(16'h301A, 16'h0104);
    wait_on(1'b1, 1'b1, n);
    chk(16'(halt), 16'h0001);
    repeat (20) @(posedge clk);
    #1;
    chk(16'(active), 16'h0000);
    send_sync();
    wait_on(1'b0, 1'b1, n);
    chk({halt, 15'(n < 8)}, 16'h0001);
    repeat (20) @(posedge clk);
    send_sync();
    wait_on(1'b0, 1'b0, n);
    wait_on(1'b1, 1'b1, n);
    chk(16'(n), 16'h0015);
    repeat (30) @(posedge clk);
    #1;
    chk({14'h0000, active, halt}, 16'h0001);
    send_sync();
    wait_on(1'b0, 1'b1, n);
    chk(16'(active), 16'h0001);
    $display("test_slave done");
  endtask

  // No subsampling, statistics on, embedded rows off, no extra delay, short frame lines.
  task automatic test_modes();
    do_reset();
    exp_step  = 16'h0002;
    exp_flags = 16'h0000;
    wr_reg(16'h30A2, 16'h0001);
    wr_reg(16'h30A6, 16'h0001);
    wr_reg(16'h3064, 16'h0080);
    wr_reg(16'h3FE0, 16'h0000);
    wr_reg(16'h301A, 16'h0004);
    wait_on(1'b0, 1'b1, n);
    t0 = cyc;
    n_black = 0;
    n_embed = 0;
    n_blank = 0;
    n_stats = 0;
    rows.delete();
    rd_reg(16'h3FE4, 16'h0001);
    wr_reg(16'h301A, 16'h0000);
    wait_on(1'b0, 1'b0, n);
    chk(16'(cyc - t0), 16'h0090);
    chk(16'(n_black), 16'h0002);
    chk(16'(n_embed), 16'h0000);
    chk(16'(n_blank), 16'h0006);
    chk(16'(n_stats), 16'h0002);
    chk(16'(rows.size()), 16'h0008);
    chk({rows[0][3:0], rows[1][3:0], rows[2][3:0], rows[7][3:0]}, 16'h0127);
    $display("test_modes done");
  endtask

  task automatic test_done();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    test_regs();
    test_free();
    test_slave();
    test_modes();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
